// ### hw/srf_pkg.sv
// Constants, types and mnemonic tables for the status report formatter
package srf_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int BERR_W = 5;
  localparam int SERR_W = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_COND = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_ERRS = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 5'h10;
  localparam int CTRL_IGN_BIT = 0;
  localparam int ERRS_SER_LSB = 8;
  localparam logic IGN_RST = 1'b1;

  // Condition word, one bit per condition
  typedef struct packed {
    logic err;
    logic timeout_flag;
    logic end_flag;
    logic service_request_seen;
    logic [2:0] rsv;
    logic done_flag;
    logic lockout_state;
    logic far_control_state;
    logic in_charge;
    logic attention;
    logic talker_active;
    logic listener_active;
    logic trigger_state;
    logic clear_state;
  } cond_t;

  // Status query arguments: continuous, numeric, symbolic
  typedef struct packed {
    logic cont;
    logic num;
    logic sym;
  } stat_req_t;

  localparam logic [15:0] COND_ERR_MASK = 16'h8000;
  localparam logic [15:0] COND_RSV_MASK = 16'h0e00;

  localparam logic [BERR_W-1:0] NO_BUS_FAULT = 5'h00;
  localparam logic [BERR_W-1:0] NOT_IN_CHARGE_FAULT = 5'h01;
  localparam logic [BERR_W-1:0] NO_LISTENER_FAULT = 5'h02;
  localparam logic [BERR_W-1:0] BAD_ADDRESSING_FAULT = 5'h03;
  localparam logic [BERR_W-1:0] BAD_ARGUMENT_FAULT = 5'h04;
  localparam logic [BERR_W-1:0] NOT_SYS_CTRL_FAULT = 5'h05;
  localparam logic [BERR_W-1:0] ABORTED_IO_FAULT = 5'h06;
  localparam logic [BERR_W-1:0] NO_CAPABILITY_FAULT = 5'h0b;
  localparam logic [BERR_W-1:0] UNSENT_COMMAND_FAULT = 5'h0e;
  localparam logic [BERR_W-1:0] UNKNOWN_COMMAND_FAULT = 5'h11;
  localparam logic [SERR_W-1:0] NO_SERIAL_FAULT = 3'h0;
  localparam logic [SERR_W-1:0] PARITY_FAULT = 3'h1;
  localparam logic [SERR_W-1:0] OVERRUN_FAULT = 3'h2;
  localparam logic [SERR_W-1:0] RX_OVERFLOW_FAULT = 3'h3;
  localparam logic [SERR_W-1:0] FRAMING_FAULT = 3'h4;

  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_ZERO = 8'h30;

  // Decimal weights, most significant first
  localparam logic [2:0] POW_LAST = 3'h4;
  localparam logic [4:0][15:0] POW10 = {16'h0001, 16'h000a, 16'h0064, 16'h03e8, 16'h2710};

  // Mnemonic text, up to four ASCII bytes, zero bytes unused
  localparam logic [15:0][31:0] COND_SYM = {
    32'h45525200, 32'h54494d4f, 32'h454e4400, 32'h53525149,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h434d504c,
    32'h4c4f4b00, 32'h52454d00, 32'h43494300, 32'h41544e00,
    32'h54414353, 32'h4c414353, 32'h44544153, 32'h44434153};
  localparam logic [17:0][31:0] BERR_SYM = {
    32'h45434d44, 32'h00000000, 32'h00000000, 32'h45425553,
    32'h00000000, 32'h00000000, 32'h45434150, 32'h00000000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h4541424f,
    32'h45534143, 32'h45415247, 32'h45414452, 32'h454e4f4c,
    32'h45434943, 32'h4e474552};
  localparam logic [4:0][31:0] SERR_SYM = {
    32'h4546524d, 32'h454f464c, 32'h454f524e, 32'h45504152, 32'h4e534552};
endpackage

// ### hw/status_report_formatter.sv
// Status snapshot keeper and CR/LF status report formatter with Avalon-MM registers
`timescale 1ns/1ns

// How it works
// - Report is condition word, bus error, serial error, count, each ending CR LF.
// - Condition word is sixteen bits, one per condition, several may be set.
// - Bit 15 is set on any bus error or any serial error not ignored, making the word negative.
// - Bits 14,13,12,8 are timeout, end, service request, done; 11 to 9 reserved.
// - Bits 7 to 0 are lockout, remote, in charge, attention, talk, listen, trigger, clear.
// - Numeric format sends decimal strings; symbolic format sends mnemonic strings, except the count, which stays decimal.
// - Continuous mode sends a report after each processed message.
// - A status query with no argument turns continuous reporting off.
// - Bus error code holds one of the listed fault values.
// - Serial error code holds one of the listed fault values.
// - Count is the byte total of the last read, write or command send.
// - Word and codes update per message; count only after transfers.
// - A plain query reports the previous message; continuous reports the current one.
// - Enabling continuous reporting returns a report at once.
// - With both formats, the numeric report is sent first.
// - Messages are taken back to back only while idle; none is taken while a report is being sent.
// - Continuous setting holds until next query, reinitialise or power off.
// - With serial errors ignored, no serial error code is reported.
module status_report_formatter (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [srf_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [srf_pkg::DATA_W-1:0] i_writedata,
  output logic [srf_pkg::DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  input wire srf_pkg::cond_t i_cond,
  input wire logic [srf_pkg::BERR_W-1:0] i_bus_err,
  input wire logic [srf_pkg::SERR_W-1:0] i_ser_err,
  input wire logic i_msg_done,
  input wire logic i_xfer_done,
  input wire logic [srf_pkg::CNT_W-1:0] i_xfer_count,
  input wire logic i_stat_valid,
  input wire srf_pkg::stat_req_t i_stat_req,
  input wire logic i_reinit,
  output logic o_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready
);
  typedef enum logic [2:0] {S_IDLE, S_ITEM, S_SIGN, S_DIG, S_SCAN, S_CHR, S_CR, S_LF} state_t;
  localparam logic [1:0] ITEM_COND = 2'h0;
  localparam logic [1:0] ITEM_BERR = 2'h1;
  localparam logic [1:0] ITEM_SERR = 2'h2;
  localparam logic [1:0] ITEM_CNT = 2'h3;

  state_t state_q, state_d;
  logic [15:0] cond_q, val_q, val_d;
  logic [srf_pkg::BERR_W-1:0] berr_q;
  logic [srf_pkg::SERR_W-1:0] serr_q;
  logic [srf_pkg::CNT_W-1:0] cnt_q;
  logic ign_q, cont_q, fnum_q, fsym_q, do_sym_q;
  logic [1:0] item_q, item_d;
  logic pass_q, pass_d, lead_q, lead_d, first_q, first_d, comma_q, comma_d;
  logic [2:0] pow_q, pow_d;
  logic [3:0] dig_q, dig_d, bit_q, bit_d;
  logic [31:0] word_q, word_d;
  logic wait_q;
  logic [srf_pkg::DATA_W-1:0] rdata_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic emit;
  logic [7:0] edata;

  // Request decode
  wire idle = (state_q == S_IDLE);
  wire stat_go = idle && i_stat_valid;
  wire msg_go = idle && i_msg_done && !i_stat_valid;
  wire xfer_go = idle && i_xfer_done;
  wire no_fmt = !i_stat_req.num && !i_stat_req.sym;
  wire start_num = stat_go ? (i_stat_req.num || no_fmt) : fnum_q;
  wire start_sym = stat_go ? i_stat_req.sym : fsym_q;
  wire start = stat_go || (msg_go && cont_q);
  wire can_emit = !tx_valid_q || i_tx_ready;

  // Snapshot of conditions at message end
  wire ser_seen = !ign_q && (i_ser_err != srf_pkg::NO_SERIAL_FAULT);
  wire any_err = (i_bus_err != srf_pkg::NO_BUS_FAULT) || ser_seen;
  wire [15:0] cond_raw = i_cond & ~(srf_pkg::COND_RSV_MASK | srf_pkg::COND_ERR_MASK);
  wire [15:0] cond_snap = cond_raw | (any_err ? srf_pkg::COND_ERR_MASK : 16'h0000);
  wire [srf_pkg::SERR_W-1:0] serr_snap = ign_q ? srf_pkg::NO_SERIAL_FAULT : i_ser_err;

  // Item selection
  wire neg = cond_q[15];
  wire [15:0] cond_mag = neg ? 16'(~cond_q + 16'h0001) : cond_q;
  wire [15:0] item_val = (item_q == ITEM_COND) ? cond_mag :
                         (item_q == ITEM_BERR) ? 16'(berr_q) :
                         (item_q == ITEM_SERR) ? 16'(serr_q) : 16'(cnt_q);
  wire [31:0] berr_sym = (berr_q <= srf_pkg::UNKNOWN_COMMAND_FAULT) ? srf_pkg::BERR_SYM[berr_q] : 32'h0;
  wire [31:0] serr_sym = (serr_q <= srf_pkg::FRAMING_FAULT) ? srf_pkg::SERR_SYM[serr_q] : 32'h0;
  wire [31:0] item_sym = (item_q == ITEM_BERR) ? berr_sym : serr_sym;
  wire [15:0] pow_val = srf_pkg::POW10[pow_q];
  wire [7:0] cur = word_q[31:24];
  wire last_pow = (pow_q == srf_pkg::POW_LAST);

  // Register read mux
  wire [srf_pkg::DATA_W-1:0] errs_word = 32'(berr_q) | (32'(serr_q) << srf_pkg::ERRS_SER_LSB);
  wire [srf_pkg::DATA_W-1:0] mode_word = 32'({!idle, fsym_q, fnum_q, cont_q});
  wire [srf_pkg::DATA_W-1:0] rd_mux =
    (i_address == srf_pkg::ADDR_CTRL) ? 32'(ign_q) << srf_pkg::CTRL_IGN_BIT :
    (i_address == srf_pkg::ADDR_COND) ? 32'(cond_q) :
    (i_address == srf_pkg::ADDR_ERRS) ? errs_word :
    (i_address == srf_pkg::ADDR_COUNT) ? 32'(cnt_q) :
    (i_address == srf_pkg::ADDR_MODE) ? mode_word : 32'h0;
  wire bus_take = wait_q && (i_read || i_write);
  wire ctrl_wr = !wait_q && i_write && (i_address == srf_pkg::ADDR_CTRL);

  always_comb begin
    state_d = state_q;
    item_d = item_q;
    pass_d = pass_q;
    val_d = val_q;
    pow_d = pow_q;
    dig_d = dig_q;
    lead_d = lead_q;
    bit_d = bit_q;
    first_d = first_q;
    word_d = word_q;
    comma_d = comma_q;
    emit = 1'b0;
    edata = 8'h00;
    unique case (state_q)
      S_IDLE: begin
        if (start) begin
          // numeric pass first when both are asked
          pass_d = !start_num;
          item_d = ITEM_COND;
          state_d = S_ITEM;
        end
      end
      S_ITEM: begin
        pow_d = 3'h0;
        dig_d = 4'h0;
        lead_d = 1'b0;
        comma_d = 1'b0;
        if (!pass_q || item_q == ITEM_CNT) begin
          val_d = item_val;
          state_d = (item_q == ITEM_COND && neg) ? S_SIGN : S_DIG;
        end else if (item_q == ITEM_COND) begin
          bit_d = 4'hf;
          first_d = 1'b1;
          state_d = S_SCAN;
        end else begin
          word_d = item_sym;
          bit_d = 4'h0;
          state_d = S_CHR;
        end
      end
      S_SIGN: begin
        if (can_emit) begin
          emit = 1'b1;
          edata = srf_pkg::CH_MINUS;
          state_d = S_DIG;
        end
      end
      S_DIG: begin
        if (val_q >= pow_val) begin
          val_d = val_q - pow_val;
          dig_d = dig_q + 4'h1;
        end else if (dig_q == 4'h0 && !lead_q && !last_pow) begin
          pow_d = pow_q + 3'h1;
        end else if (can_emit) begin
          emit = 1'b1;
          edata = srf_pkg::CH_ZERO | {4'h0, dig_q};
          lead_d = 1'b1;
          dig_d = 4'h0;
          if (last_pow) begin
            state_d = S_CR;
          end else begin
            pow_d = pow_q + 3'h1;
          end
        end
      end
      S_SCAN: begin
        // highest set bit first, commas between
        if (cond_q[bit_q] && srf_pkg::COND_SYM[bit_q] != 32'h0) begin
          word_d = srf_pkg::COND_SYM[bit_q];
          comma_d = !first_q;
          first_d = 1'b0;
          state_d = S_CHR;
        end else if (bit_q == 4'h0) begin
          state_d = S_CR;
        end else begin
          bit_d = bit_q - 4'h1;
        end
      end
      S_CHR: begin
        if (comma_q) begin
          if (can_emit) begin
            emit = 1'b1;
            edata = srf_pkg::CH_COMMA;
            comma_d = 1'b0;
          end
        end else if (cur == 8'h00 || can_emit) begin
          emit = (cur != 8'h00);
          edata = cur;
          word_d = word_q << 8;
          if (cur == 8'h00 || word_q[23:16] == 8'h00) begin
            if (bit_q == 4'h0) begin
              state_d = S_CR;
            end else begin
              bit_d = bit_q - 4'h1;
              state_d = S_SCAN;
            end
          end
        end
      end
      S_CR: begin
        // every item closed by CR LF
        if (can_emit) begin
          emit = 1'b1;
          edata = srf_pkg::CH_CR;
          state_d = S_LF;
        end
      end
      S_LF: begin
        if (can_emit) begin
          emit = 1'b1;
          edata = srf_pkg::CH_LF;
          if (item_q != ITEM_CNT) begin
            item_d = item_q + 2'h1;
            state_d = S_ITEM;
          end else if (!pass_q && do_sym_q) begin
            pass_d = 1'b1;
            item_d = ITEM_COND;
            state_d = S_ITEM;
          end else begin
            state_d = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      {item_q, pass_q, val_q, pow_q, dig_q, lead_q} <= '0;
      {bit_q, first_q, word_q, comma_q, do_sym_q} <= '0;
      {tx_valid_q, tx_data_q} <= '0;
    end else begin
      state_q <= state_d;
      {item_q, pass_q, val_q, pow_q, dig_q, lead_q} <= {item_d, pass_d, val_d, pow_d, dig_d, lead_d};
      {bit_q, first_q, word_q, comma_q} <= {bit_d, first_d, word_d, comma_d};
      if (start) do_sym_q <= start_sym;
      tx_valid_q <= emit || (tx_valid_q && !i_tx_ready);
      if (emit) tx_data_q <= edata;
    end
  end

  // Snapshot, count and mode state
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {cond_q, berr_q, serr_q, cnt_q} <= '0;
      {cont_q, fnum_q, fsym_q} <= '0;
      ign_q <= srf_pkg::IGN_RST;
    end else begin
      // word and codes per message; ignored serial code reads none
      if (msg_go) {cond_q, berr_q, serr_q} <= {cond_snap, i_bus_err, serr_snap};
      if (xfer_go) cnt_q <= i_xfer_count;
      // every query sets continuous from its argument; reinitialise clears it; held otherwise
      if (stat_go) {cont_q, fnum_q, fsym_q} <= {i_stat_req.cont, start_num, start_sym};
      else if (idle && i_reinit) {cont_q, fnum_q, fsym_q} <= '0;
      if (idle && i_reinit) ign_q <= srf_pkg::IGN_RST;
      else if (ctrl_wr) ign_q <= i_writedata[srf_pkg::CTRL_IGN_BIT];
    end
  end

  // Avalon slave: one wait cycle per access
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= !bus_take;
      if (bus_take && i_read) rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_ready <= 1'b1;
    // ready again the cycle after a report ends
    else o_ready <= (state_d == S_IDLE);
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_tx_valid = tx_valid_q;
  assign o_tx_data = tx_data_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_err_sign_set: assert property (msg_go |=> cond_q[15] == $past(any_err))
    else $error("error bit does not follow fault codes");
  a_rsv_bits_zero: assert property ((cond_q & srf_pkg::COND_RSV_MASK) == 16'h0)
    else $error("reserved condition bits set");
  a_ser_ignored: assert property (msg_go && ign_q |=> serr_q == srf_pkg::NO_SERIAL_FAULT)
    else $error("serial code reported while ignored");
  a_count_take: assert property (xfer_go |=> cnt_q == $past(i_xfer_count))
    else $error("count not taken from transfer");
  a_count_hold: assert property (msg_go && !i_xfer_done |=> $stable(cnt_q))
    else $error("count changed without transfer");
  a_noarg_off: assert property (stat_go && !i_stat_req.cont |=> !cont_q ##1 !o_ready)
    else $error("query without continuous left it on");
  a_cont_report: assert property (msg_go && cont_q |=> state_q == S_ITEM ##1 !o_ready)
    else $error("no automatic report after message");
  a_cont_immediate: assert property (stat_go && i_stat_req.cont |=> cont_q && state_q == S_ITEM)
    else $error("continuous enable gave no report");
  a_cr_then_lf: assert property (state_q == S_CR && emit |=> state_q == S_LF && tx_data_q == srf_pkg::CH_CR)
    else $error("item not closed by CR then LF");
  a_num_before_sym: assert property ($rose(pass_q) |-> ($past(state_q) == S_LF && $past(item_q) == ITEM_CNT) ||
    ($past(state_q) == S_IDLE && !fnum_q))
    else $error("symbolic pass began before numeric ended");
  a_tx_stable: assert property (tx_valid_q && !i_tx_ready |=> tx_valid_q && $stable(tx_data_q))
    else $error("byte dropped under back-pressure");

  c_both_formats: cover property (stat_go && i_stat_req.num && i_stat_req.sym);
  c_cont_report: cover property (msg_go && cont_q);
  c_negative_word: cover property (state_q == S_SIGN && emit);
  c_sym_only: cover property (stat_go && i_stat_req.sym && !i_stat_req.num);
endmodule

// ### tb/report_sink.sv
// Host side model that takes the report byte stream
`timescale 1ns/1ns
module report_sink (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic [1:0] pace_q;
  logic [7:0] rx_q[$];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pace_q <= 2'h0;
      o_tx_ready <= 1'b0;
    end else begin
      pace_q <= pace_q + 2'h1;
      o_tx_ready <= !i_slow || (pace_q == 2'h3);
    end
  end
  always @(posedge i_clk) begin
    if (!i_rst && i_tx_valid && o_tx_ready) begin
      rx_q.push_back(i_tx_data);
    end
  end
endmodule

// ### tb/tb_status_report_formatter.sv
// Testbench for the status report formatter
`timescale 1ns/1ns
module tb_status_report_formatter;
  logic i_clk, i_rst, rd, wr, msg, xfer, stv, rein, slow, wait_rq, rdy, tx_valid, tx_ready;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [7:0] tx_data;
  logic [4:0] be;
  logic [2:0] se;
  logic [15:0] cnt;
  srf_pkg::cond_t cond_in;
  srf_pkg::stat_req_t req;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  string s;
  logic [4:0] bcode[10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0b, 5'h0e, 5'h11};

  status_report_formatter i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(wait_rq), .i_cond(cond_in), .i_bus_err(be),
    .i_ser_err(se), .i_msg_done(msg), .i_xfer_done(xfer), .i_xfer_count(cnt), .i_stat_valid(stv),
    .i_stat_req(req), .i_reinit(rein), .o_ready(rdy), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready));
  report_sink i_host (.i_clk(i_clk), .i_rst(i_rst), .i_slow(slow), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge i_clk);
    rd <= !is_wr;
    wr <= is_wr;
    addr <= a;
    wdata <= wd;
    do begin
      @(posedge i_clk);
    end while (wait_rq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, d);
    check(d, exp, what);
  endtask

  // Command pulse: 0 message end, 1 transfer, 2 status query, 3 reinitialise
  task automatic cmd(input int k, input logic [2:0] r);
    do begin
      @(posedge i_clk);
    end while (rdy !== 1'b1);
    req <= r;
    msg <= (k == 0);
    xfer <= (k == 1);
    stv <= (k == 2);
    rein <= (k == 3);
    @(posedge i_clk);
    msg <= 1'b0;
    xfer <= 1'b0;
    stv <= 1'b0;
    rein <= 1'b0;
  endtask

  task automatic wait_rep(input string exp, input string what);
    repeat (4) @(posedge i_clk);
    do begin
      @(posedge i_clk);
    end while (rdy !== 1'b1 || tx_valid !== 1'b0);
    repeat (2) @(posedge i_clk);
    s = "";
    while (i_host.rx_q.size() > 0) s = $sformatf("%s%c", s, i_host.rx_q.pop_front());
    samples_checked++;
    if (s != exp) begin
      fail_count++;
      $display("mismatch at %0t: %s report text differs", $time, what);
    end
  endtask

  function automatic string sy(input logic [31:0] v);
    string r = "";
    for (int i = 3; i >= 0; i--) begin
      if (v[i*8+:8] != 8'h00) r = $sformatf("%s%c", r, v[i*8+:8]);
    end
    return r;
  endfunction

  function automatic string sym_rep(input logic [15:0] v, input logic [4:0] b, input logic [2:0] e,
                                    input logic [15:0] c);
    string l;
    l = "";
    for (int i = 15; i >= 0; i--) begin
      if (v[i] && l != "") l = {l, ","};
      if (v[i]) l = {l, sy(srf_pkg::COND_SYM[i])};
    end
    return {l, "\015\012", sy(srf_pkg::BERR_SYM[b]), "\015\012", sy(srf_pkg::SERR_SYM[e]),
            $sformatf("\015\012%0d\015\012", c)};
  endfunction

  function automatic string rep(input logic [15:0] v, input logic [4:0] b, input logic [2:0] e,
                                input logic [15:0] c, input logic sym);
    string r;
    r = $sformatf("%0d\015\012%0d\015\012%0d\015\012%0d\015\012", $signed(v), b, e, c);
    if (sym) r = {r, sym_rep(v, b, e, c)};
    return r;
  endfunction

  function automatic logic [15:0] xw(input logic [15:0] c, input logic [4:0] b, input logic [2:0] e, input logic ign);
    return (c & 16'h71ff) | ((b != 5'h00 || (e != 3'h0 && !ign)) ? 16'h8000 : 16'h0000);
  endfunction

  initial begin
    i_rst = 1'b1;
    {rd, wr, msg, xfer, stv, rein, slow} = 7'h00;
    addr = 5'h00;
    wdata = 32'h0;
    cond_in = 16'h0000;
    be = 5'h00;
    se = 3'h0;
    cnt = 16'h0000;
    req = 3'h0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(srf_pkg::ADDR_CTRL, 32'h1, "ctrl reset");
    rd_chk(srf_pkg::ADDR_COND, 32'h0, "cond reset");
    rd_chk(srf_pkg::ADDR_COUNT, 32'h0, "count reset");
    rd_chk(srf_pkg::ADDR_MODE, 32'h0, "mode reset");
    bus(1'b1, 5'h14, 32'hffffffff, d);
    rd_chk(5'h14, 32'h0, "unmapped");
    bus(1'b1, srf_pkg::ADDR_COND, 32'hffff, d);
    rd_chk(srf_pkg::ADDR_COND, 32'h0, "cond read only");
    bus(1'b1, srf_pkg::ADDR_CTRL, 32'h0, d);
    for (int i = 0; i < 10; i++) begin
      be <= bcode[i];
      se <= 3'(i % 5);
      cond_in <= 16'h0100;
      cmd(0, 3'h0);
      rd_chk(srf_pkg::ADDR_ERRS, {21'h0, 3'(i % 5), 3'h0, bcode[i]}, "codes");
      rd_chk(srf_pkg::ADDR_COND, {16'h0, xw(16'h0100, bcode[i], 3'(i % 5), 1'b0)}, "error bit");
    end
    cond_in <= 16'hffff;
    be <= 5'h11;
    se <= 3'h4;
    cnt <= 16'hffff;
    @(posedge i_clk);
    msg <= 1'b1;
    @(posedge i_clk);
    msg <= 1'b0;
    xfer <= 1'b1;
    @(posedge i_clk);
    xfer <= 1'b0;
    rd_chk(srf_pkg::ADDR_COND, 32'hf1ff, "all bits");
    rd_chk(srf_pkg::ADDR_COUNT, 32'hffff, "count");
    cmd(2, 3'b010);
    wait_rep(rep(16'hf1ff, 5'h11, 3'h4, 16'hffff, 1'b0), "numeric");
    slow <= 1'b1;
    cmd(2, 3'b111);
    wait_rep(rep(16'hf1ff, 5'h11, 3'h4, 16'hffff, 1'b1), "both formats");
    rd_chk(srf_pkg::ADDR_MODE, 32'h7, "mode cont");
    cond_in <= 16'h0128;
    be <= 5'h00;
    se <= 3'h0;
    cmd(0, 3'h0);
    wait_rep(rep(16'h0128, 5'h00, 3'h0, 16'hffff, 1'b1), "automatic");
    cmd(2, 3'b000);
    wait_rep(rep(16'h0128, 5'h00, 3'h0, 16'hffff, 1'b0), "plain query");
    bus(1'b0, srf_pkg::ADDR_MODE, 32'h0, d);
    check(d & 32'h1, 32'h0, "cont off");
    cmd(2, 3'b001);
    wait_rep(sym_rep(16'h0128, 5'h00, 3'h0, 16'hffff), "symbolic only");
    cmd(0, 3'h0);
    wait_rep("", "no report");
    bus(1'b1, srf_pkg::ADDR_CTRL, 32'h1, d);
    cond_in <= 16'h0004;
    se <= 3'h2;
    cmd(0, 3'h0);
    rd_chk(srf_pkg::ADDR_ERRS, 32'h0, "serial ignored");
    rd_chk(srf_pkg::ADDR_COND, 32'h4, "no error bit");
    cmd(2, 3'b110);
    wait_rep(rep(16'h0004, 5'h00, 3'h0, 16'hffff, 1'b0), "cont numeric");
    bus(1'b1, srf_pkg::ADDR_CTRL, 32'h0, d);
    cmd(3, 3'h0);
    rd_chk(srf_pkg::ADDR_MODE, 32'h0, "reinit mode");
    rd_chk(srf_pkg::ADDR_CTRL, 32'h1, "reinit ignore");
    cmd(0, 3'h0);
    wait_rep("", "after reinit");
    final_report();
  end
endmodule
